// File: cfmr_pkg.sv
package cfmr_pkg;

    localparam int WORD_W      = 36;
    localparam int DEPTH       = 512;
    localparam int ADDR_W      = 9;
    localparam int PTR_W       = ADDR_W + 1;
    localparam int OFS_W       = 9;
    localparam int SERIAL_BITS = 2 * OFS_W;
    localparam int SER_CNT_W   = 5;

    localparam logic [PTR_W-1:0] DEPTH_PTR = 10'h200;
    localparam logic [OFS_W-1:0] PRESET_LO = 9'h008;
    localparam logic [OFS_W-1:0] PRESET_HI = 9'h040;
    localparam logic [OFS_W-1:0] OFS_RESET = 9'h000;

    localparam logic [SER_CNT_W-1:0] SER_LAST = 5'h11;

    localparam int FULL_OFS_HI  = SERIAL_BITS - 1;
    localparam int FULL_OFS_LO  = OFS_W;
    localparam int EMPTY_OFS_HI = OFS_W - 1;

    localparam logic [WORD_W-1:0] DATA_RESET = 36'h0_0000_0000;
    localparam logic [PTR_W-1:0]  PTR_RESET  = 10'h000;

    typedef enum logic [1:0] {
        CFMR_SEL_PARALLEL,
        CFMR_SEL_PRESET_LO,
        CFMR_SEL_PRESET_HI,
        CFMR_SEL_SERIAL
    } cfmr_sel_t;

    typedef enum logic [2:0] {
        CFMR_INIT,
        CFMR_LOAD_FULL,
        CFMR_LOAD_EMPTY,
        CFMR_SHIFT,
        CFMR_RUN
    } cfmr_mode_t;

    typedef struct packed {
        logic [PTR_W-1:0]  ptr;
        logic [WORD_W-1:0] data;
    } cfmr_word_t;

    localparam int SLOT_W = $bits(cfmr_word_t);

endpackage

// File: cfmr_buf.sv
`timescale 1ns/10ps

module cfmr_buf #(
    parameter int W = 46
) (
    // Clock, reset, freeze and discard.
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         ce,
    input  wire logic         flush,
    // Filling side.
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Draining side.
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);

    logic [W-1:0] slot [2];
    logic         wp;
    logic         rp;
    logic [1:0]   cnt;
    logic         push;
    logic         pop;

    assign in_ready  = (cnt != 2'h2);
    assign out_valid = (cnt != 2'h0);
    assign out_data  = slot[rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (ce && push) begin
            slot[wp] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wp  <= 1'b0;
            rp  <= 1'b0;
            cnt <= 2'h0;
        end else if (ce) begin
            if (flush) begin
                wp  <= 1'b0;
                rp  <= 1'b0;
                cnt <= 2'h0;
            end else begin
                if (push) begin
                    wp <= ~wp;
                end
                if (pop) begin
                    rp <= ~rp;
                end
                cnt <= cnt + {1'b0, push} - {1'b0, pop};
            end
        end
    end

endmodule

// File: cfmr_fifo.sv
`timescale 1ns/10ps

module cfmr_fifo (
    // Clock, reset and freeze.
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    input  wire logic                         ce,
    // Port A controls.
    input  wire logic                         port_a_chip_select_n,
    input  wire logic                         port_a_gate,
    input  wire logic                         port_a_mailbox_select,
    input  wire logic                         port_a_direction,
    // Port A data pins.
    input  wire logic [cfmr_pkg::WORD_W-1:0]  port_a_bus_in,
    output logic [cfmr_pkg::WORD_W-1:0]       port_a_bus_out,
    output logic                              port_a_bus_oe,
    // Port B controls.
    input  wire logic                         port_b_chip_select_n,
    input  wire logic                         port_b_gate,
    input  wire logic                         port_b_mailbox_select,
    input  wire logic                         port_b_direction,
    // Port B data pins.
    input  wire logic [cfmr_pkg::WORD_W-1:0]  port_b_bus_in,
    output logic [cfmr_pkg::WORD_W-1:0]       port_b_bus_out,
    output logic                              port_b_bus_oe,
    // Retransmit controls.
    input  wire logic                         retransmit_mark_mode,
    input  wire logic                         retransmit_rewind,
    // Offset select and serial load.
    input  wire logic                         offset_select_hi_serial_enable,
    input  wire logic                         offset_select_lo_serial_data,
    // Status flags.
    output logic                              input_ready,
    output logic                              almost_full_n,
    output logic                              output_ready,
    output logic                              almost_empty_n,
    output logic                              mail_one_flag_n,
    output logic                              mail_two_flag_n
);
    import cfmr_pkg::*;

    logic [WORD_W-1:0]  mem [DEPTH];
    logic [PTR_W-1:0]   wr_ptr;
    logic [PTR_W-1:0]   rd_ptr;
    logic [PTR_W-1:0]   rel_ptr;
    logic [PTR_W-1:0]   mark_ptr;
    logic               rt_mode;
    cfmr_mode_t         mode;
    logic               rst_q;
    logic [SERIAL_BITS-1:0] offs;
    logic [SER_CNT_W-1:0]   ser_cnt;
    logic [WORD_W-1:0]  mail_one;
    logic [WORD_W-1:0]  mail_two;
    logic               rd_valid;
    cfmr_word_t         rd_word;
    cfmr_word_t         buf_word;
    logic               buf_in_ready;
    logic               buf_out_valid;
    cfmr_word_t         out_word;
    logic               ir_s1;
    logic               af_s1;
    logic               ae_s1;

    logic               a_cycle;
    logic               b_cycle;
    logic               a_write;
    logic               mem_write;
    logic               mail_one_write;
    logic               mail_two_read;
    logic               mail_two_write;
    logic               mail_one_read;
    logic               fifo_read;
    logic               rewind_go;
    logic               mark_go;
    logic               fetch_go;
    logic               load_out;
    logic [PTR_W-1:0]   base_ptr;
    logic [PTR_W-1:0]   used;
    logic [PTR_W-1:0]   stored;
    logic [PTR_W-1:0]   free_cnt;
    logic               full;
    logic               ir_raw;
    logic               af_raw;
    logic               ae_raw;
    cfmr_sel_t          next_sel;

    // Port qualifiers.
    assign a_cycle        = !port_a_chip_select_n && port_a_gate;
    assign b_cycle        = !port_b_chip_select_n && port_b_gate;
    assign a_write        = a_cycle && port_a_direction && !port_a_mailbox_select && input_ready && !full;
    assign mem_write      = a_write && (mode == CFMR_RUN);
    assign mail_one_write = a_cycle && port_a_direction && port_a_mailbox_select;
    assign mail_two_read  = a_cycle && !port_a_direction && port_a_mailbox_select;
    assign mail_two_write = b_cycle && !port_b_direction && port_b_mailbox_select;
    assign mail_one_read  = b_cycle && port_b_direction && port_b_mailbox_select;
    assign fifo_read      = b_cycle && port_b_direction && !port_b_mailbox_select && output_ready;
    assign rewind_go      = rt_mode && retransmit_rewind;
    assign mark_go        = retransmit_mark_mode && output_ready && !rt_mode;

    // Occupancy: locations stay reserved until read from the output register,
    // or from the mark onward while retransmit is armed.
    assign base_ptr = rt_mode ? mark_ptr : rel_ptr;
    assign used     = wr_ptr - base_ptr;
    assign stored   = wr_ptr - rel_ptr;
    assign free_cnt = DEPTH_PTR - used;
    assign full     = (used == DEPTH_PTR);
    assign ir_raw   = !full && (mode != CFMR_INIT) && (mode != CFMR_SHIFT);
    assign af_raw   = (free_cnt <= {1'b0, offs[FULL_OFS_HI:FULL_OFS_LO]});
    assign ae_raw   = (stored <= {1'b0, offs[EMPTY_OFS_HI:0]});

    // Data pins: port A reads show the second mailbox, port B the first or the queue.
    assign port_a_bus_oe  = !port_a_chip_select_n && !port_a_direction;
    assign port_a_bus_out = mail_two;
    assign port_b_bus_oe  = !port_b_chip_select_n && port_b_direction;
    assign port_b_bus_out = port_b_mailbox_select ? mail_one : out_word.data;

    // Offset method decode at the release of reset.
    always_comb begin
        next_sel = cfmr_sel_t'({offset_select_hi_serial_enable, offset_select_lo_serial_data});
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rst_q <= 1'b0;
        end else if (ce) begin
            rst_q <= 1'b1;
        end
    end

    // Offset programming sequence.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mode    <= CFMR_INIT;
            offs    <= {OFS_RESET, OFS_RESET};
            ser_cnt <= '0;
        end else if (ce) begin
            unique case (mode)
                CFMR_INIT: begin
                    if (!rst_q) begin
                        unique case (next_sel)
                            CFMR_SEL_SERIAL: begin
                                mode <= CFMR_SHIFT;
                            end
                            CFMR_SEL_PRESET_HI: begin
                                offs <= {PRESET_HI, PRESET_HI};
                                mode <= CFMR_RUN;
                            end
                            CFMR_SEL_PRESET_LO: begin
                                offs <= {PRESET_LO, PRESET_LO};
                                mode <= CFMR_RUN;
                            end
                            CFMR_SEL_PARALLEL: begin
                                mode <= CFMR_LOAD_FULL;
                            end
                        endcase
                    end
                end
                CFMR_LOAD_FULL: begin
                    if (a_write) begin
                        offs[FULL_OFS_HI:FULL_OFS_LO] <= port_a_bus_in[OFS_W-1:0];
                        mode <= CFMR_LOAD_EMPTY;
                    end
                end
                CFMR_LOAD_EMPTY: begin
                    if (a_write) begin
                        offs[EMPTY_OFS_HI:0] <= port_a_bus_in[OFS_W-1:0];
                        mode <= CFMR_RUN;
                    end
                end
                CFMR_SHIFT: begin
                    if (!offset_select_hi_serial_enable) begin
                        offs    <= {offs[SERIAL_BITS-2:0], offset_select_lo_serial_data};
                        ser_cnt <= ser_cnt + 5'h01;
                        if (ser_cnt == SER_LAST) begin
                            mode <= CFMR_RUN;
                        end
                    end
                end
                CFMR_RUN: begin
                    mode <= CFMR_RUN;
                end
            endcase
        end
    end

    // Array write side.
    always_ff @(posedge clk) begin
        if (ce && mem_write) begin
            mem[wr_ptr[ADDR_W-1:0]] <= port_a_bus_in;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_ptr <= PTR_RESET;
        end else if (ce && mem_write) begin
            wr_ptr <= wr_ptr + 10'h001;
        end
    end

    // Fetch stage: one word leaves the array per edge while the buffer accepts.
    assign fetch_go = (rd_ptr != wr_ptr) && (!rd_valid || buf_in_ready) && !rewind_go;

    always_ff @(posedge clk) begin
        if (ce && fetch_go) begin
            rd_word.ptr  <= rd_ptr;
            rd_word.data <= mem[rd_ptr[ADDR_W-1:0]];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rd_ptr   <= PTR_RESET;
            rd_valid <= 1'b0;
        end else if (ce) begin
            if (rewind_go) begin
                rd_ptr   <= mark_ptr;
                rd_valid <= 1'b0;
            end else begin
                if (fetch_go) begin
                    rd_ptr <= rd_ptr + 10'h001;
                end
                rd_valid <= fetch_go || (rd_valid && !buf_in_ready);
            end
        end
    end

    cfmr_buf #(
        .W (SLOT_W)
    ) u_buf (
        .clk       (clk),
        .rst_b     (rst_b),
        .ce        (ce),
        .flush     (rewind_go),
        .in_valid  (rd_valid),
        .in_ready  (buf_in_ready),
        .in_data   (rd_word),
        .out_valid (buf_out_valid),
        .out_ready (load_out),
        .out_data  (buf_word)
    );

    // Output register and its ready flag.
    assign load_out = buf_out_valid && (!output_ready || fifo_read) && !rewind_go;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            out_word <= '{ptr: PTR_RESET, data: DATA_RESET};
        end else if (ce && load_out) begin
            out_word <= buf_word;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            output_ready <= 1'b0;
        end else if (ce) begin
            if (rewind_go) begin
                output_ready <= 1'b0;
            end else if (load_out) begin
                output_ready <= 1'b1;
            end else if (fifo_read) begin
                output_ready <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rel_ptr <= PTR_RESET;
        end else if (ce) begin
            if (rewind_go) begin
                rel_ptr <= mark_ptr;
            end else if (fifo_read) begin
                rel_ptr <= rel_ptr + 10'h001;
            end
        end
    end

    // Retransmit mark.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rt_mode  <= 1'b0;
            mark_ptr <= PTR_RESET;
        end else if (ce) begin
            if (!retransmit_mark_mode) begin
                rt_mode <= 1'b0;
            end else if (mark_go) begin
                rt_mode  <= 1'b1;
                mark_ptr <= out_word.ptr;
            end
        end
    end

    // Flag synchronisers.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ir_s1         <= 1'b0;
            input_ready   <= 1'b0;
            af_s1         <= 1'b1;
            almost_full_n <= 1'b1;
            ae_s1         <= 1'b0;
            almost_empty_n <= 1'b0;
        end else if (ce) begin
            ir_s1          <= ir_raw;
            input_ready    <= ir_s1;
            af_s1          <= !af_raw;
            almost_full_n  <= af_s1;
            ae_s1          <= !ae_raw;
            almost_empty_n <= ae_s1;
        end
    end

    // Mailboxes; a new message beats a read in the same edge.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mail_one        <= DATA_RESET;
            mail_one_flag_n <= 1'b1;
        end else if (ce) begin
            if (mail_one_write) begin
                mail_one        <= port_a_bus_in;
                mail_one_flag_n <= 1'b0;
            end else if (mail_one_read) begin
                mail_one_flag_n <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mail_two        <= DATA_RESET;
            mail_two_flag_n <= 1'b1;
        end else if (ce) begin
            if (mail_two_write) begin
                mail_two        <= port_b_bus_in;
                mail_two_flag_n <= 1'b0;
            end else if (mail_two_read) begin
                mail_two_flag_n <= 1'b1;
            end
        end
    end

    // Checks.
    property p_ir_sync;
        @(posedge clk) disable iff (!rst_b)
        ce && $past(ce) |=> input_ready == $past(ir_raw, 2);
    endproperty
    a_ir_sync: assert property (p_ir_sync) else $error("input ready not two stages behind fullness");

    property p_ae_level;
        @(posedge clk) disable iff (!rst_b)
        ce ##1 ce |-> almost_empty_n == !$past(ae_raw, 2);
    endproperty
    a_ae_level: assert property (p_ae_level) else $error("almost empty flag wrong");

    property p_af_level;
        @(posedge clk) disable iff (!rst_b)
        ce ##1 ce |-> almost_full_n == !$past(af_raw, 2);
    endproperty
    a_af_level: assert property (p_af_level) else $error("almost full flag wrong");

    property p_no_write_when_blocked;
        @(posedge clk) disable iff (!rst_b)
        (!input_ready || full) |=> $stable(wr_ptr);
    endproperty
    a_no_write_when_blocked: assert property (p_no_write_when_blocked) else $error("write taken while blocked");

    property p_mail_one;
        @(posedge clk) disable iff (!rst_b)
        ce && mail_one_write |=> !mail_one_flag_n && mail_one == $past(port_a_bus_in);
    endproperty
    a_mail_one: assert property (p_mail_one) else $error("mail one not posted");

    property p_mail_two_clear;
        @(posedge clk) disable iff (!rst_b)
        ce && mail_two_read && !mail_two_write |=> mail_two_flag_n;
    endproperty
    a_mail_two_clear: assert property (p_mail_two_clear) else $error("mail two flag not cleared");

    property p_third_edge;
        @(posedge clk) disable iff (!rst_b)
        (ce && mem_write && wr_ptr == rd_ptr && !rd_valid && !buf_out_valid && !output_ready)
        ##1 (ce && !rewind_go)[*3] |=> output_ready;
    endproperty
    a_third_edge: assert property (p_third_edge) else $error("output ready late");

    property p_rewind;
        @(posedge clk) disable iff (!rst_b)
        ce && rewind_go |=> rd_ptr == $past(mark_ptr) && !output_ready;
    endproperty
    a_rewind: assert property (p_rewind) else $error("rewind did not reload pointer");

    property p_mark;
        @(posedge clk) disable iff (!rst_b)
        ce && mark_go |=> rt_mode && mark_ptr == $past(out_word.ptr);
    endproperty
    a_mark: assert property (p_mark) else $error("mark not taken");

    property p_leave_mode;
        @(posedge clk) disable iff (!rst_b)
        ce && !retransmit_mark_mode |=> !rt_mode;
    endproperty
    a_leave_mode: assert property (p_leave_mode) else $error("retransmit mode not left");

endmodule

// File: cfmr_peer.sv
`timescale 1ns/10ps

module cfmr_peer (
    // Clock, queue status and read data.
    input  wire logic                        clk,
    input  wire logic                        output_ready,
    input  wire logic [cfmr_pkg::WORD_W-1:0] port_b_bus_out,
    // Port B controls and write data.
    output logic                             port_b_chip_select_n,
    output logic                             port_b_gate,
    output logic                             port_b_mailbox_select,
    output logic                             port_b_direction,
    output logic [cfmr_pkg::WORD_W-1:0]      port_b_bus_in
);
    import cfmr_pkg::*;

    initial begin
        port_b_chip_select_n = 1'b1;
        port_b_gate = 1'b0;
        port_b_mailbox_select = 1'b0;
        port_b_direction = 1'b1;
        port_b_bus_in = DATA_RESET;
    end

    // Takes one word; for a queue read the gate rises only after output_ready is seen high or 60 edges pass.
    task automatic pop(input logic mbx, output logic [WORD_W-1:0] q);
        int n;
        n = 0;
        @(posedge clk);
        port_b_chip_select_n <= 1'b0;
        port_b_direction <= 1'b1;
        port_b_mailbox_select <= mbx;
        #1;
        while (!mbx && output_ready !== 1'b1 && n < 60) begin
            @(posedge clk);
            #1;
            n++;
        end
        q = port_b_bus_out;
        @(posedge clk);
        port_b_gate <= 1'b1;
        @(posedge clk);
        port_b_gate <= 1'b0;
        port_b_chip_select_n <= 1'b1;
    endtask

    // Leaves a word in the mailbox towards port A; the bus shows the inverse once released.
    task automatic post(input logic [WORD_W-1:0] d);
        @(posedge clk);
        port_b_chip_select_n <= 1'b0;
        port_b_direction <= 1'b0;
        port_b_mailbox_select <= 1'b1;
        port_b_gate <= 1'b1;
        port_b_bus_in <= d;
        @(posedge clk);
        port_b_gate <= 1'b0;
        port_b_chip_select_n <= 1'b1;
        port_b_bus_in <= ~d;
    endtask
endmodule

// File: tb_cfmr_fifo.sv
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; $display("[FAIL] %0t %h %h", $time, g, e); end end

module tb_cfmr_fifo;
    import cfmr_pkg::*;

    localparam logic [SERIAL_BITS-1:0] SER_OFS = 18'h0_0602;

    logic                clk, rst_b, ce, port_a_chip_select_n, port_a_gate, port_a_mailbox_select;
    logic                port_a_direction, port_a_bus_oe, port_b_bus_oe, retransmit_mark_mode;
    logic                retransmit_rewind, offset_select_hi_serial_enable, offset_select_lo_serial_data;
    logic                input_ready, almost_full_n, output_ready, almost_empty_n;
    logic                mail_one_flag_n, mail_two_flag_n, port_b_chip_select_n, port_b_gate;
    logic                port_b_mailbox_select, port_b_direction;
    logic [WORD_W-1:0]   port_a_bus_in, port_a_bus_out, port_b_bus_in, port_b_bus_out, a_q, b_q;
    int                  comparisons, miscompares, wcnt, rcnt, mark;

    cfmr_fifo i_dut (.clk, .rst_b, .ce, .port_a_chip_select_n, .port_a_gate, .port_a_mailbox_select,
        .port_a_direction, .port_a_bus_in, .port_a_bus_out, .port_a_bus_oe, .port_b_chip_select_n,
        .port_b_gate, .port_b_mailbox_select, .port_b_direction, .port_b_bus_in, .port_b_bus_out,
        .port_b_bus_oe, .retransmit_mark_mode, .retransmit_rewind, .offset_select_hi_serial_enable,
        .offset_select_lo_serial_data, .input_ready, .almost_full_n, .output_ready, .almost_empty_n,
        .mail_one_flag_n, .mail_two_flag_n);

    cfmr_peer i_peer (.clk, .output_ready, .port_b_bus_out, .port_b_chip_select_n, .port_b_gate,
        .port_b_mailbox_select, .port_b_direction, .port_b_bus_in);

    always #20 clk = ~clk;

    function automatic logic [WORD_W-1:0] val(input int k);
        return 36'h5_0000_0000 + 36'(k);
    endfunction

    task automatic a_op(input logic dir, input logic mbx, input logic [WORD_W-1:0] d);
        @(posedge clk);
        port_a_chip_select_n <= 1'b0;
        port_a_gate <= 1'b1;
        port_a_direction <= dir;
        port_a_mailbox_select <= mbx;
        port_a_bus_in <= d;
        #1;
        a_q = port_a_bus_out;
        @(posedge clk);
        port_a_gate <= 1'b0;
        port_a_chip_select_n <= 1'b1;
        port_a_bus_in <= ~d;
    endtask

    task automatic push();
        a_op(1'b1, 1'b0, val(wcnt));
        wcnt++;
    endtask

    task automatic pull();
        i_peer.pop(1'b0, b_q);
        `CHK(b_q, val(rcnt))
        rcnt++;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic end_sim();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #(40 * 20000);
        miscompares++;
        end_sim();
    end

    initial begin
        {clk, rst_b, port_a_gate, port_a_mailbox_select, retransmit_mark_mode, retransmit_rewind} = '0;
        {ce, port_a_chip_select_n, port_a_direction} = '1;
        {offset_select_hi_serial_enable, offset_select_lo_serial_data} = 2'b01;
        port_a_bus_in = DATA_RESET;
        {comparisons, miscompares, wcnt, rcnt} = '0;
        tick(3);
        `CHK(input_ready, 1'b0)
        `CHK(output_ready, 1'b0)
        `CHK(almost_empty_n, 1'b0)
        `CHK(almost_full_n, 1'b1)
        `CHK(mail_one_flag_n & mail_two_flag_n, 1'b1)
        `CHK(port_a_bus_oe | port_b_bus_oe, 1'b0)
        @(posedge clk);
        rst_b <= 1'b1;
        tick(4);
        `CHK(input_ready, 1'b1)
        push();
        tick(2);
        `CHK(output_ready, 1'b0)
        tick(1);
        `CHK(output_ready, 1'b1)
        repeat (8) push();
        tick(4);
        `CHK(almost_empty_n, 1'b1)
        pull();
        tick(4);
        `CHK(almost_empty_n, 1'b0)
        @(posedge clk);
        retransmit_mark_mode <= 1'b1;
        mark = rcnt;
        @(posedge clk);
        pull();
        pull();
        @(posedge clk);
        retransmit_rewind <= 1'b1;
        @(posedge clk);
        retransmit_rewind <= 1'b0;
        tick(2);
        rcnt = mark;
        pull();
        @(posedge clk);
        retransmit_mark_mode <= 1'b0;
        @(posedge clk);
        retransmit_rewind <= 1'b1;
        @(posedge clk);
        retransmit_rewind <= 1'b0;
        tick(2);
        pull();
        a_op(1'b1, 1'b1, 36'hA_5A5A_0F0F);
        tick(1);
        `CHK(mail_one_flag_n, 1'b0)
        i_peer.pop(1'b1, b_q);
        `CHK(b_q, 36'hA_5A5A_0F0F)
        tick(1);
        `CHK(mail_one_flag_n, 1'b1)
        i_peer.post(36'h3_C3C3_7E7E);
        tick(1);
        `CHK(mail_two_flag_n, 1'b0)
        a_op(1'b0, 1'b1, DATA_RESET);
        `CHK(a_q, 36'h3_C3C3_7E7E)
        tick(1);
        `CHK(mail_two_flag_n, 1'b1)
        while (rcnt < wcnt) pull();
        while (wcnt - rcnt < 503) push();
        tick(4);
        `CHK(almost_full_n, 1'b1)
        push();
        tick(4);
        `CHK(almost_full_n, 1'b0)
        while (wcnt - rcnt < 512) push();
        tick(4);
        `CHK(input_ready, 1'b0)
        a_op(1'b1, 1'b0, DATA_RESET);
        while (rcnt < wcnt) pull();
        tick(4);
        `CHK(output_ready, 1'b0)
        @(posedge clk);
        rst_b <= 1'b0;
        {offset_select_hi_serial_enable, offset_select_lo_serial_data} <= 2'b11;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = SERIAL_BITS - 1; i >= 0; i--) begin
            @(posedge clk);
            offset_select_hi_serial_enable <= 1'b0;
            offset_select_lo_serial_data   <= SER_OFS[i];
        end
        @(posedge clk);
        offset_select_hi_serial_enable <= 1'b1;
        tick(1);
        `CHK(input_ready, 1'b0)
        tick(1);
        `CHK(input_ready, 1'b1)
        repeat (2) push();
        tick(4);
        `CHK(almost_empty_n, 1'b0)
        push();
        tick(4);
        `CHK(almost_empty_n, 1'b1)
        while (rcnt < wcnt) pull();
        @(posedge clk);
        rst_b <= 1'b0;
        {offset_select_hi_serial_enable, offset_select_lo_serial_data} <= 2'b00;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        tick(4);
        `CHK(input_ready, 1'b1)
        a_op(1'b1, 1'b0, 36'hF_FFFF_FE05);
        a_op(1'b1, 1'b0, 36'hF_FFFF_FE04);
        repeat (4) push();
        tick(4);
        `CHK(almost_empty_n, 1'b0)
        push();
        tick(4);
        `CHK(almost_empty_n, 1'b1)
        while (rcnt < wcnt) pull();
        tick(4);
        `CHK(output_ready, 1'b0)
        end_sim();
    end
endmodule
